/* src/oam_addr_gen.v */
// Operand address generator for the byte-oriented core.
`timescale 1ns/1ps
`include "oam_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Direct mode takes the operand location from the instruction's 8-bit address field.
// - Direct mode reaches only internal RAM and special function registers.
// - 8-bit indirect uses pointer_reg_zero or pointer_reg_one, chosen by the instruction.
// - 16-bit indirect uses the data_pointer contents as the address.
// - Register mode selects one of eight working registers of the active bank from the opcode.
// - Register-specific instructions use the implied register such as the accumulator.
// - Immediate mode yields the instruction bytes as the operand value, not an address.
// - Indexed addressing is only allowed for program-memory reads.
// - Indexed address is data_pointer plus the accumulator.
// - Bit mode selects one bit out of a 256-bit space.
// - 128 bit addresses map to internal RAM, the rest to special function register bits.
// - External data transfers use only indirect addressing and only the accumulator.
module oam_addr_gen #(
	parameter AW = 16                  // Operand address width
) (
	input  wire          clk,          // Core clock
	input  wire          srst,         // Synchronous reset, active high
	input  wire          instr_valid,  // Decoded instruction present
	input  wire [2:0]    mode,         // Addressing mode
	input  wire [7:0]    opcode,       // Opcode byte
	input  wire [7:0]    operand,      // First operand byte of the instruction
	input  wire [7:0]    operand2,     // Second operand byte (high immediate)
	input  wire          is_write,     // Access writes its operand
	input  wire          to_xdata,     // Access targets external data space
	input  wire          wide_ptr,     // Indirect through the data pointer
	input  wire          acc_side,     // The accumulator is the other end of the move
	input  wire [7:0]    psw,          // Program status register
	input  wire [7:0]    accumulator,  // Accumulator value
	input  wire [15:0]   data_pointer, // Data pointer value
	input  wire [7:0]    pointer_reg_zero, // Working register 0 of the active bank
	input  wire [7:0]    pointer_reg_one,  // Working register 1 of the active bank
	output reg  [AW-1:0] op_addr,      // Resolved operand address
	output reg  [2:0]    op_space,     // Space the address belongs to
	output reg  [15:0]   op_imm,       // Immediate operand value
	output reg  [2:0]    op_bit,       // Bit position for bit mode
	output reg           op_is_write,  // Resolved access writes
	output reg           op_valid,     // Result valid, one cycle
	output reg           op_illegal    // Request refused, one cycle
);
	////////////////////////////////////////////////////////////////////////////
	reg  [AW-1:0] next_addr;
	reg  [2:0]    next_space;
	reg  [15:0]   next_imm;
	reg  [2:0]    next_bit;
	reg           next_bad;
	wire [1:0]    bank;
	wire [7:0]    bit_byte;
	wire [2:0]    bit_pos;
	wire          bit_in_sfr;
	wire [7:0]    ptr8;
	wire [AW-1:0] ptr8_addr;
	wire [AW-1:0] direct_addr;
	wire [AW-1:0] reg_addr;
	wire [AW-1:0] index_addr;
	wire [AW-1:0] bit_addr_wide;
	wire          take;
	wire          refuse;
	genvar        gi;

	assign bank = psw[`OAM_PSW_BANK_LSB+1:`OAM_PSW_BANK_LSB];

	// pointer choice
	// One select per bit keeps the pick a plain mux row, with no priority between the two.
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_ptr
			assign ptr8[gi] = opcode[0] ? pointer_reg_one[gi] : pointer_reg_zero[gi];
		end
	endgenerate

	oam_bit_decode u_bit (
		.bit_addr  (operand),
		.byte_addr (bit_byte),
		.bit_pos   (bit_pos),
		.in_sfr    (bit_in_sfr)
	);

	////////////////////////////////////////////////////////////////////////////
	// Candidate addresses are widened here so the mode case below only selects.
	// direct address field
	assign direct_addr   = {{(AW-8){1'b0}}, operand};
	assign ptr8_addr     = {{(AW-8){1'b0}}, ptr8};
	assign reg_addr      = {{(AW-5){1'b0}}, bank, opcode[2:0]};
	// base plus offset
	// The sum wraps at the top of program memory, so the carry out is dropped on purpose.
	assign index_addr    = data_pointer[AW-1:0] + {{(AW-8){1'b0}}, accumulator};
	assign bit_addr_wide = {{(AW-8){1'b0}}, bit_byte};

	////////////////////////////////////////////////////////////////////////////
	// Operand location and value for the presented mode.
	always @* begin
		next_addr  = {AW{1'b0}};
		next_space = `OAM_SPACE_NONE;
		next_imm   = 16'h0000;
		next_bit   = 3'h0;
		case (mode)
		`OAM_MODE_DIRECT: begin
			next_addr = direct_addr;
			if (operand >= `OAM_SFR_BASE) begin
				next_space = `OAM_SPACE_SFR;
			end else begin
				next_space = `OAM_SPACE_IRAM;
			end
		end
		`OAM_MODE_INDIRECT: begin
			if (wide_ptr) begin
				next_addr = data_pointer[AW-1:0];
			end else begin
				next_addr = ptr8_addr;
			end
			if (to_xdata) begin
				next_space = `OAM_SPACE_XDATA;
			end else begin
				next_space = `OAM_SPACE_IRAM;
			end
		end
		`OAM_MODE_REGISTER: begin
			next_addr  = reg_addr;
			next_space = `OAM_SPACE_IRAM;
		end
		`OAM_MODE_IMPLIED: begin
			next_space = `OAM_SPACE_ACC;
		end
		`OAM_MODE_IMMED: begin
			next_imm   = {operand2, operand};
			next_space = `OAM_SPACE_IMMED;
		end
		`OAM_MODE_INDEXED: begin
			next_addr  = index_addr;
			next_space = `OAM_SPACE_CODE;
		end
		`OAM_MODE_BIT: begin
			next_addr = bit_addr_wide;
			next_bit  = bit_pos;
			if (bit_in_sfr) begin
				next_space = `OAM_SPACE_SFR;
			end else begin
				next_space = `OAM_SPACE_IRAM;
			end
		end
		default: begin
			next_space = `OAM_SPACE_NONE;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Legality is decoded apart from the select so the refusal table reads in one place.
	always @* begin
		next_bad = 1'b0;
		case (mode)
		`OAM_MODE_INDIRECT: begin
			if (to_xdata) begin
				next_bad = ~acc_side;
			end else begin
				// Wide pointer cannot reach internal RAM, so it is refused there.
				next_bad = wide_ptr;
			end
		end
		`OAM_MODE_DIRECT,
		`OAM_MODE_REGISTER,
		`OAM_MODE_IMPLIED,
		`OAM_MODE_BIT: begin
			next_bad = to_xdata;
		end
		`OAM_MODE_IMMED: begin
			// Immediate values are constants, so a write to one is refused.
			next_bad = is_write | to_xdata;
		end
		`OAM_MODE_INDEXED: begin
			next_bad = is_write | to_xdata;
		end
		default: begin
			next_bad = 1'b1;
		end
		endcase
	end

	assign take   = instr_valid & ~next_bad;
	assign refuse = instr_valid & next_bad;

	////////////////////////////////////////////////////////////////////////////
	// The answer pulses stand for one cycle only; the core must take them at that edge.
	always @(posedge clk) begin
		if (srst) begin
			op_valid   <= 1'b0;
			op_illegal <= 1'b0;
		end else begin
			op_valid   <= take;
			op_illegal <= refuse;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// A refused request leaves the address outputs cleared so no space is touched.
	always @(posedge clk) begin
		if (srst) begin
			op_addr     <= {AW{1'b0}};
			op_space    <= `OAM_SPACE_NONE;
			op_imm      <= 16'h0000;
			op_bit      <= 3'h0;
			op_is_write <= 1'b0;
		end else if (take) begin
			op_addr     <= next_addr;
			op_space    <= next_space;
			op_imm      <= next_imm;
			op_bit      <= next_bit;
			op_is_write <= is_write;
		end else begin
			op_addr     <= {AW{1'b0}};
			op_space    <= `OAM_SPACE_NONE;
			op_imm      <= 16'h0000;
			op_bit      <= 3'h0;
			op_is_write <= 1'b0;
		end
	end
endmodule

/* src/oam_bit_decode.v */
// Bit address decoder: maps a bit address to a byte address and bit position.
`timescale 1ns/1ps
`include "oam_map.vh"
module oam_bit_decode (
	input  wire [7:0] bit_addr,   // Bit address from the instruction
	output wire [7:0] byte_addr,  // Byte holding the bit
	output wire [2:0] bit_pos,    // Bit position within the byte
	output wire       in_sfr      // High when the bit lives in a special function register
);
	assign in_sfr = (bit_addr >= `OAM_BIT_MID);
	assign byte_addr = in_sfr ? {bit_addr[7:3], 3'b000}
	                          : (`OAM_BIT_RAM_BASE + {3'b000, bit_addr[7:3]});
	assign bit_pos = bit_addr[2:0];
endmodule

/* src/oam_map.vh */
// Constants for the operand addressing block.
`ifndef OAM_MAP_VH
`define OAM_MAP_VH
// Operand addressing modes.
`define OAM_MODE_DIRECT   3'h0
`define OAM_MODE_INDIRECT 3'h1
`define OAM_MODE_REGISTER 3'h2
`define OAM_MODE_IMPLIED  3'h3
`define OAM_MODE_IMMED    3'h4
`define OAM_MODE_INDEXED  3'h5
`define OAM_MODE_BIT      3'h6
`define OAM_MODE_NONE     3'h7
// Target spaces.
`define OAM_SPACE_NONE    3'h0
`define OAM_SPACE_IRAM    3'h1
`define OAM_SPACE_SFR     3'h2
`define OAM_SPACE_XDATA   3'h3
`define OAM_SPACE_CODE    3'h4
`define OAM_SPACE_ACC     3'h5
`define OAM_SPACE_IMMED   3'h6
// Direct addresses at or above this value select the special function registers.
`define OAM_SFR_BASE      8'h80
// Bit space midpoint and bit-addressable internal RAM base byte.
`define OAM_BIT_MID       8'h80
`define OAM_BIT_RAM_BASE  8'h20
// Bank-select field position in the program status register.
`define OAM_PSW_BANK_LSB  3
// Reset values.
`define OAM_RST_ADDR      16'h0000
`define OAM_RST_BYTE      8'h00
`endif

/* test/oam_addr_gen_props.sv */
// Port assertions for the operand address generator.
`timescale 1ns/1ps
module oam_addr_gen_props #(
	parameter AW = 16 // Address width
) (
	input logic          clk,              // Clock
	input logic          srst,             // Reset
	input logic          instr_valid,      // Request
	input logic [2:0]    mode,             // Mode
	input logic [7:0]    opcode,           // Opcode
	input logic [7:0]    operand,          // Operand
	input logic [7:0]    operand2,         // High byte
	input logic          is_write,         // Write
	input logic          to_xdata,         // External
	input logic          wide_ptr,         // Wide
	input logic          acc_side,         // Acc end
	input logic [7:0]    psw,              // Status
	input logic [7:0]    accumulator,      // Acc
	input logic [15:0]   data_pointer,     // Pointer
	input logic [7:0]    pointer_reg_zero, // Reg 0
	input logic [7:0]    pointer_reg_one,  // Reg 1
	input logic [AW-1:0] op_addr,          // Address
	input logic [2:0]    op_space,         // Space
	input logic [15:0]   op_imm,           // Immediate
	input logic [2:0]    op_bit,           // Bit
	input logic          op_is_write,      // Write copy
	input logic          op_valid,         // Done
	input logic          op_illegal        // Refused
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_direct_field:
	assert property (instr_valid && mode == 3'h0 && !to_xdata |=> op_valid
		&& op_addr == $past(operand) && op_space == ($past(operand[7]) ? 3'h2 : 3'h1))
		else $error("direct address wrong");
	a_ptr_pick:
	assert property (instr_valid && mode == 3'h1 && !wide_ptr && !to_xdata |=> op_addr ==
		($past(opcode[0]) ? $past(pointer_reg_one) : $past(pointer_reg_zero)))
		else $error("pointer register wrong");
	a_wide_ptr:
	assert property (instr_valid && mode == 3'h1 && wide_ptr && to_xdata && acc_side
		|=> op_addr == $past(data_pointer) && op_space == 3'h3) else $error("wide pointer wrong");
	a_xdata_refused:
	assert property (instr_valid && to_xdata && mode != 3'h1 |=> op_illegal && !op_valid)
		else $error("external access not refused");
	a_reg_bank:
	assert property (instr_valid && mode == 3'h2 && !to_xdata
		|=> op_addr == {$past(psw[4:3]), $past(opcode[2:0])}) else $error("register wrong");
	a_imm_value:
	assert property (instr_valid && mode == 3'h4 && !is_write && !to_xdata
		|=> op_imm == {$past(operand2), $past(operand)}) else $error("immediate wrong");
	a_index_sum:
	assert property (instr_valid && mode == 3'h5 && !is_write && !to_xdata |=> op_space == 3'h4
		&& op_addr == $past(data_pointer) + $past(accumulator)) else $error("index sum wrong");
	a_index_write:
	assert property (instr_valid && mode == 3'h5 && is_write |=> op_illegal && !op_valid)
		else $error("indexed write not refused");
	a_bit_split:
	assert property (instr_valid && mode == 3'h6 && !to_xdata |=> op_bit == $past(operand[2:0])
		&& op_addr == ($past(operand[7]) ? {$past(operand[7:3]), 3'h0} : 8'h20 + $past(operand[7:3])))
		else $error("bit decode wrong");
	sequence s_no_req;
		!instr_valid;
	endsequence
	sequence s_outputs_clear;
		!op_valid && !op_illegal && op_space == 3'h0 && op_addr == '0 && op_imm == 16'h0000;
	endsequence
	sequence s_refused;
		op_illegal && !op_valid && op_space == 3'h0 && op_addr == '0;
	endsequence
	a_idle_clear:
	assert property (s_no_req |=> s_outputs_clear) else $error("idle outputs not clear");
	a_pulse_exclusive:
	assert property (!(op_valid && op_illegal)) else $error("valid and refused together");
	a_write_copy:
	assert property (instr_valid && mode == 3'h0 && !to_xdata |=> op_is_write == $past(is_write))
		else $error("write flag wrong");
	a_mode_refused:
	assert property (instr_valid && mode == 3'h7 |=> s_refused) else $error("bad mode not refused");
	a_wide_iram:
	assert property (instr_valid && mode == 3'h1 && wide_ptr && !to_xdata |=> s_refused)
		else $error("wide pointer to ram not refused");
	a_imm_write:
	assert property (instr_valid && mode == 3'h4 && is_write |=> s_refused ##0 op_imm == 16'h0000)
		else $error("immediate write not refused");
endmodule
bind oam_addr_gen oam_addr_gen_props #(.AW(AW)) u_props (.*);

/* test/oam_addr_gen_tb_top.sv */
// Self-checking bench for the operand address generator.
`timescale 1ns/1ps
module oam_addr_gen_tb_top;
	logic        clk, srst, iv, wr, xd, wp, as;
	logic [2:0]  md;
	logic [7:0]  oc, o1, o2, psw, acc, r0, r1;
	logic [15:0] dp;
	wire  [15:0] addr, imm;
	wire  [2:0]  sp, bp;
	wire         ov, oi, wo;
	int          fail_count = 0;
	int          n_checks = 0;
	oam_addr_gen uut (.clk(clk), .srst(srst), .instr_valid(iv), .mode(md), .opcode(oc),
		.operand(o1), .operand2(o2), .is_write(wr), .to_xdata(xd), .wide_ptr(wp),
		.acc_side(as), .psw(psw), .accumulator(acc), .data_pointer(dp),
		.pointer_reg_zero(r0), .pointer_reg_one(r1), .op_addr(addr), .op_space(sp),
		.op_imm(imm), .op_bit(bp), .op_is_write(wo), .op_valid(ov), .op_illegal(oi));
	task chk(input logic [47:0] g, input logic [47:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Flags are {write, external, wide, acc end}; the result lands one edge after the take.
	task go(input logic [2:0] m, input logic [7:0] c, a, b, input logic [3:0] f);
		@(posedge clk);
		md <= m; oc <= c; o1 <= a; o2 <= b; {wr, xd, wp, as} <= f; iv <= 1'b1;
		@(posedge clk);
		iv <= 1'b0;
		#1;
	endtask
	task t_direct;
		go(3'h0, 8'h00, 8'h7F, 8'h00, 4'h0); chk(addr, 16'h007F); chk(sp, 3'h1);
		go(3'h0, 8'h00, 8'h80, 8'h00, 4'h0); chk(addr, 16'h0080); chk(sp, 3'h2);
		go(3'h0, 8'h00, 8'h10, 8'h00, 4'h4); chk({ov, oi}, 2'h1);
		go(3'h0, 8'h00, 8'h30, 8'h00, 4'h8); chk({wo, sp, addr}, {1'b1, 3'h1, 16'h0030});
	endtask
	task t_indir;
		@(posedge clk);
		r0 <= 8'h11; r1 <= 8'h22; dp <= 16'hBEEF;
		go(3'h1, 8'h01, 8'h00, 8'h00, 4'h5); chk({sp, addr}, {3'h3, 16'h0022});
		go(3'h1, 8'h00, 8'h00, 8'h00, 4'h2); chk({ov, oi, addr}, {2'h1, 16'h0000});
		go(3'h1, 8'h01, 8'h00, 8'h00, 4'h0); chk(addr, 16'h0022);
		go(3'h1, 8'h06, 8'h00, 8'h00, 4'h0); chk(addr, 16'h0011);
		go(3'h1, 8'h00, 8'h00, 8'h00, 4'h7); chk(addr, 16'hBEEF); chk(sp, 3'h3);
		go(3'h1, 8'h00, 8'h00, 8'h00, 4'h6); chk(oi, 1'b1);
	endtask
	task t_reg_imm;
		@(posedge clk);
		psw <= 8'h10;
		go(3'h4, 8'h00, 8'h34, 8'h12, 4'h8); chk({ov, oi, imm}, {2'h1, 16'h0000});
		go(3'h2, 8'h07, 8'h00, 8'h00, 4'h0); chk(addr, 16'h0017);
		go(3'h3, 8'h00, 8'h00, 8'h00, 4'h0); chk(sp, 3'h5);
		go(3'h4, 8'h00, 8'h34, 8'h12, 4'h0); chk(imm, 16'h1234); chk(sp, 3'h6);
	endtask
	task t_index;
		@(posedge clk);
		dp <= 16'hFFF0; acc <= 8'h20;
		go(3'h5, 8'h00, 8'h00, 8'h00, 4'h0); chk(addr, 16'h0010); chk(sp, 3'h4);
		go(3'h5, 8'h00, 8'h00, 8'h00, 4'h8); chk({ov, oi}, 2'h1);
	endtask
	// Illegal mode, one idle cycle, then a request made while reset is held.
	task t_reset;
		go(3'h7, 8'h00, 8'h55, 8'h66, 4'h0); chk({ov, oi, sp, addr, imm}, {2'h1, 35'h0});
		@(posedge clk);
		#1;
		chk({ov, oi, sp, addr, imm}, 37'h0);
		@(posedge clk);
		srst <= 1'b1; md <= 3'h0; o1 <= 8'h44; iv <= 1'b1;
		@(posedge clk);
		iv <= 1'b0;
		#1;
		chk({ov, oi, sp, addr}, 21'h0);
		@(posedge clk);
		srst <= 1'b0;
		#1;
		chk({ov, oi, sp, addr}, 21'h0);
		go(3'h0, 8'h00, 8'h44, 8'h00, 4'h0); chk({ov, addr}, {1'b1, 16'h0044});
	endtask
	task t_bit;
		go(3'h6, 8'h00, 8'h7F, 8'h00, 4'h0); chk({sp, bp, addr}, {3'h1, 3'h7, 16'h002F});
		go(3'h6, 8'h00, 8'h83, 8'h00, 4'h0); chk({sp, bp, addr}, {3'h2, 3'h3, 16'h0080});
	endtask
	task test_done;
		if (fail_count == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		{iv, wr, xd, wp, as, md, oc, o1, o2, psw, acc, r0, r1, dp} = '0;
		srst = 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		#1;
		chk({ov, oi, sp, bp, wo, addr, imm}, 41'h0);
		t_direct;
		t_indir;
		t_reg_imm;
		t_index;
		t_reset;
		t_bit;
		test_done;
	end
endmodule
